/* File: verilog/psc_protocol_config.v */
// Volatile protocol configuration register of a serial flash, reached by its read and
// write commands on the serial bus, with the derived protocol settings as outputs.
// Assumes the serial clock, chip select and data lines are asynchronous pins sampled by clk,
// and that the serial clock runs well below a quarter of the clk rate.
`timescale 1ns/100ps
`include "psc_map.vh"

module psc_protocol_config #(
  parameter [7:0] WR_OPCODE = `PSC_CMD_WRITE,
  parameter [7:0] RD_OPCODE = `PSC_CMD_READ,
  parameter LINE3_IS_RESET = 0
) (
  input wire clk,
  input wire rst_n,
  input wire sclk,
  input wire csN,
  input wire [3:0] dqIn,
  input wire rescueReq,
  output reg [3:0] dqOut,
  output reg [3:0] dqOe,
  output reg [7:0] cfgValue,
  output reg quadMode,
  output reg dualMode,
  output reg doubleRate,
  output reg holdResetEn
);

  // ****************************************************************
  // Pin synchronisation and edge detection
  // ****************************************************************
  wire sclkS;
  wire csNS;
  wire [3:0] dqS;
  reg sclkPrev_r;
  reg csPrev_r;

  psc_sync #(.WIDTH(6)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({sclk, csN, dqIn}),
    .dout({sclkS, csNS, dqS})
  );

  // Line three acts as hold or reset only when it is not carrying quad data.
  wire line3Ctl = holdResetEn & ~quadMode & ~dqS[3];
  wire pauseFrame = line3Ctl & (LINE3_IS_RESET == 0);
  wire hwReset = line3Ctl & (LINE3_IS_RESET != 0) & csNS;

  wire riseE = sclkS & ~sclkPrev_r & ~csNS & ~pauseFrame;
  wire fallE = ~sclkS & sclkPrev_r & ~csNS & ~pauseFrame;
  wire inEdge = riseE | (doubleRate & fallE);
  wire outEdge = fallE | (doubleRate & riseE);
  wire frameStart = ~csNS & csPrev_r;
  wire frameEnd = csNS & ~csPrev_r;

  // ****************************************************************
  // Lane width and byte assembly
  // ****************************************************************
  reg [3:0] lanes_nxt;
  reg [7:0] byteIn_nxt;
  localparam [2:0] ST_IDLE = `PSC_ST_IDLE;
  localparam [2:0] ST_CMD = `PSC_ST_CMD;
  localparam [2:0] ST_WDATA = `PSC_ST_WDATA;
  localparam [2:0] ST_RDATA = `PSC_ST_RDATA;
  localparam [2:0] ST_SKIP = `PSC_ST_SKIP;
  reg [2:0] state_r;
  reg [3:0] inCnt_r;
  reg [7:0] shIn_r;
  reg [3:0] outCnt_r;
  reg [7:0] shOut_r;
  reg [7:0] pend_r;
  reg pendValid_r;

  always @*
  begin
    lanes_nxt = `PSC_LANES_1;
    byteIn_nxt = {shIn_r[6:0], dqS[0]};
    if (quadMode)
    begin
      lanes_nxt = `PSC_LANES_4;
      byteIn_nxt = {shIn_r[3:0], dqS};
    end
    else if (dualMode)
    begin
      lanes_nxt = `PSC_LANES_2;
      byteIn_nxt = {shIn_r[5:0], dqS[1:0]};
    end
  end

  wire [3:0] inCntNxt = inCnt_r + lanes_nxt;
  wire byteDone = inEdge && (inCntNxt == `PSC_BYTE_BITS);
  wire [7:0] outSrc = (outCnt_r == 4'h0) ? cfgValue : shOut_r;
  wire [3:0] outCntNxt = outCnt_r + lanes_nxt;

  reg [3:0] drive_nxt;
  reg [3:0] oe_nxt;
  reg [7:0] shOut_nxt;

  always @*
  begin
    drive_nxt = {2'b00, outSrc[7], 1'b0};
    oe_nxt = `PSC_OE_SINGLE;
    shOut_nxt = {outSrc[6:0], 1'b0};
    if (quadMode)
    begin
      drive_nxt = outSrc[7:4];
      oe_nxt = `PSC_OE_QUAD;
      shOut_nxt = {outSrc[3:0], 4'h0};
    end
    else if (dualMode)
    begin
      drive_nxt = {2'b00, outSrc[7:6]};
      oe_nxt = `PSC_OE_DUAL;
      shOut_nxt = {outSrc[5:0], 2'b00};
    end
  end

  // ****************************************************************
  // Register and derived protocol settings
  // ****************************************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfgValue <= `PSC_CFG_DEFAULT;
      quadMode <= 1'b0;
      dualMode <= 1'b0;
      doubleRate <= 1'b0;
      holdResetEn <= 1'b1;
    end
    else if (rescueReq || hwReset)
    begin
      cfgValue <= `PSC_CFG_DEFAULT;
      quadMode <= 1'b0;
      dualMode <= 1'b0;
      doubleRate <= 1'b0;
      holdResetEn <= 1'b1;
    end
    else if (frameEnd && pendValid_r)
    begin
      cfgValue <= pend_r;
      quadMode <= ~pend_r[`PSC_BIT_QUAD];
      dualMode <= pend_r[`PSC_BIT_QUAD] & ~pend_r[`PSC_BIT_DUAL];
      doubleRate <= ~pend_r[`PSC_BIT_RATE];
      holdResetEn <= pend_r[`PSC_BIT_HOLD];
    end
  end

  // ****************************************************************
  // Command framing
  // ****************************************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclkPrev_r <= 1'b1;
      csPrev_r <= 1'b1;
      state_r <= ST_IDLE;
      inCnt_r <= 4'h0;
      shIn_r <= 8'h00;
      outCnt_r <= 4'h0;
      shOut_r <= 8'h00;
      pend_r <= `PSC_CFG_DEFAULT;
      pendValid_r <= 1'b0;
      dqOut <= 4'h0;
      dqOe <= `PSC_OE_NONE;
    end
    else
    begin
      sclkPrev_r <= sclkS;
      csPrev_r <= csNS;
      if (frameEnd || rescueReq || hwReset || csNS)
      begin
        state_r <= ST_IDLE;
        pendValid_r <= 1'b0;
        dqOe <= `PSC_OE_NONE;
        dqOut <= 4'h0;
      end
      else if (frameStart)
      begin
        state_r <= ST_CMD;
        inCnt_r <= 4'h0;
        outCnt_r <= 4'h0;
      end
      else
      begin
        if (inEdge)
        begin
          shIn_r <= byteIn_nxt;
          inCnt_r <= byteDone ? 4'h0 : inCntNxt;
        end
        case (state_r)
          ST_CMD:
          begin
            if (byteDone)
            begin
              if (byteIn_nxt == WR_OPCODE)
                state_r <= ST_WDATA;
              else if (byteIn_nxt == RD_OPCODE)
                state_r <= ST_RDATA;
              else
                state_r <= ST_SKIP;
            end
          end
          ST_WDATA:
          begin
            if (byteDone)
            begin
              // Reserved low bits are fixed at one whatever the host sends.
              pend_r <= {byteIn_nxt[`PSC_FIELD_HI], `PSC_RSVD_ONES};
              pendValid_r <= 1'b1;
              state_r <= ST_SKIP;
            end
          end
          ST_RDATA:
          begin
            if (outEdge)
            begin
              dqOut <= drive_nxt;
              dqOe <= oe_nxt;
              shOut_r <= shOut_nxt;
              outCnt_r <= (outCntNxt == `PSC_BYTE_BITS) ? 4'h0 : outCntNxt;
            end
          end
          ST_SKIP:
          begin
            state_r <= ST_SKIP;
          end
          default:
          begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // psc_protocol_config

/* File: verilog/psc_map.vh */
// Field layout, defaults, opcodes and state codes of the protocol configuration register.
// Assumes inclusion by bare name from the design files of this block.
`ifndef PSC_MAP_VH
`define PSC_MAP_VH

// ****************************************************************
// Register layout
// ****************************************************************
`define PSC_CFG_DEFAULT 8'hFF
`define PSC_BIT_QUAD 7
`define PSC_BIT_DUAL 6
`define PSC_BIT_RATE 5
`define PSC_BIT_HOLD 4
`define PSC_FIELD_HI 7:4
`define PSC_RSVD_ONES 4'hF

// ****************************************************************
// Command opcodes (arbitrary defaults)
// ****************************************************************
`define PSC_CMD_WRITE 8'hA1
`define PSC_CMD_READ 8'hA5

// ****************************************************************
// Lane widths, byte size and output enables
// ****************************************************************
`define PSC_LANES_1 4'h1
`define PSC_LANES_2 4'h2
`define PSC_LANES_4 4'h4
`define PSC_BYTE_BITS 4'h8
`define PSC_OE_NONE 4'h0
`define PSC_OE_SINGLE 4'h2
`define PSC_OE_DUAL 4'h3
`define PSC_OE_QUAD 4'hF

// ****************************************************************
// Frame states
// ****************************************************************
`define PSC_ST_IDLE 3'h0
`define PSC_ST_CMD 3'h1
`define PSC_ST_WDATA 3'h2
`define PSC_ST_RDATA 3'h3
`define PSC_ST_SKIP 3'h4

`endif

/* File: verilog/psc_sync.v */
// Two flip-flop synchroniser for a group of asynchronous pin levels.
// Assumes each bit is an independent level; nothing but the second stage reads the first.
`timescale 1ns/100ps
module psc_sync #(
  parameter WIDTH = 6
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] stage1_r;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_r <= {WIDTH{1'b1}};
      dout <= {WIDTH{1'b1}};
    end
    else
    begin
      stage1_r <= din;
      dout <= stage1_r;
    end
  end

endmodule // psc_sync

/* File: test/psc_protocol_config_checker.sv */
// Port checks of the protocol configuration register.
// Assumes one clock domain and the documented reset value of the register.
`timescale 1ns/100ps
module psc_cfg_checker (
  input wire clk,
  input wire rst_n,
  input wire sclk,
  input wire csN,
  input wire [3:0] dqIn,
  input wire rescueReq,
  input wire [3:0] dqOut,
  input wire [3:0] dqOe,
  input wire [7:0] cfgValue,
  input wire quadMode,
  input wire dualMode,
  input wire doubleRate,
  input wire holdResetEn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_quad; quadMode == !cfgValue[7]; endproperty
  a_quad: assert property (p_quad) else $error("quad mode wrong");
  property p_dual; dualMode == (cfgValue[7] && !cfgValue[6]); endproperty
  a_dual: assert property (p_dual) else $error("dual mode wrong");
  property p_rate; doubleRate == !cfgValue[5]; endproperty
  a_rate: assert property (p_rate) else $error("rate wrong");
  property p_hold; holdResetEn == cfgValue[4]; endproperty
  a_hold: assert property (p_hold) else $error("hold enable wrong");
  property p_apply; !$stable(cfgValue) && !$past(rescueReq) |-> csN; endproperty
  a_apply: assert property (p_apply) else $error("change inside frame");
  property p_boot; $rose(rst_n) |-> cfgValue == 8'hFF && !quadMode; endproperty
  a_boot: assert property (p_boot) else $error("reset value wrong");
  property p_rescue; rescueReq |=> cfgValue == 8'hFF && !dualMode && !doubleRate; endproperty
  a_rescue: assert property (p_rescue) else $error("rescue failed");
  property p_idle; csN [*5] |-> dqOe == 4'h0; endproperty
  a_idle: assert property (p_idle) else $error("driving while idle");
  c_quad: cover property (quadMode);
  c_rate: cover property (doubleRate);
  c_qread: cover property (dqOe == 4'hF);
endmodule // psc_cfg_checker
bind psc_protocol_config psc_cfg_checker u_psc_cfg_checker (.clk, .rst_n, .sclk, .csN, .dqIn,
  .rescueReq, .dqOut, .dqOe, .cfgValue, .quadMode, .dualMode, .doubleRate, .holdResetEn);

/* File: test/psc_host_model.sv */
// Serial host that runs one command frame per call.
// Assumes pull-ups on the data lines and the default opcodes.
`timescale 1ns/100ps
`include "psc_map.vh"
module psc_host_model (
  input wire clk,
  input wire [3:0] dqOut,
  input wire [3:0] dqOe,
  output reg sclk,
  output reg csN,
  output wire [3:0] dqIn
);
  reg [3:0] hostDq = 4'hF;
  reg [3:0] capt;
  reg holdLow = 1'b0;
  // Released lines float high, which also keeps the hold line inactive.
  // Setting holdLow pulls line three low to pause the device.
  assign dqIn = ((dqOe & dqOut) | (~dqOe & hostDq)) & {~holdLow, 3'h7};
  initial
  begin
    sclk = 1'b0;
    csN = 1'b1;
  end
  // Data moves mid-phase so it never changes together with a clock edge.
  task beat(input [3:0] d);
  begin
    repeat (2) @(posedge clk);
    hostDq <= d;
    repeat (2) @(posedge clk);
    capt = dqOut;
    // An 80 ns serial clock stays far below every read limit, so no latch tuning is needed.
    sclk <= ~sclk;
  end
  endtask
  function [3:0] lane(input [7:0] b, input integer n);
    lane = (n == 1) ? {3'h7, b[7]} : (n == 2) ? {2'h3, b[7:6]} : b[7:4];
  endfunction
  task frame(input [7:0] op, input [7:0] wd, input integer n, input ddr, output [7:0] rd);
    integer i;
    reg [3:0] d;
  begin
    csN <= 1'b0;
    rd = 8'h00;
    repeat (2) @(posedge clk);
    for (i = 0; i < 8; i = i + n)
    begin
      beat(lane(op << i, n));
      if (!ddr) beat(lane(op << i, n));
    end
    if (op == `PSC_CMD_READ && ddr) beat(4'hF);
    for (i = 0; i < 8; i = i + n)
    begin
      d = (op == `PSC_CMD_READ) ? 4'hF : lane(wd << i, n);
      beat(d);
      rd = (rd << n) | ((n == 1) ? {3'h0, capt[1]} : capt & ((4'h1 << n) - 4'h1));
      if (!ddr) beat(d);
    end
    repeat (4) @(posedge clk);
    if (sclk) beat(4'hF);
    repeat (4) @(posedge clk);
    csN <= 1'b1;
    hostDq <= 4'hF;
    repeat (12) @(posedge clk);
  end
  endtask
endmodule // psc_host_model

/* File: test/tb_top.sv */
// Self-checking bench of the protocol configuration register.
// Assumes the host model and the bound checker beside the design.
`timescale 1ns/100ps
`include "psc_map.vh"
module tb_top;
  reg clk;
  reg rst_n = 1'b0;
  reg rescueReq = 1'b0;
  wire sclk, csN, quadMode, dualMode, doubleRate, holdResetEn;
  wire [3:0] dqIn, dqOut, dqOe;
  wire [7:0] cfgValue;
  reg [7:0] rd;
  integer failCount = 0, checked = 0, cyc = 0;
  psc_protocol_config u_psc_protocol_config (.clk, .rst_n, .sclk, .csN, .dqIn, .rescueReq,
    .dqOut, .dqOe, .cfgValue, .quadMode, .dualMode, .doubleRate, .holdResetEn);
  psc_host_model u_psc_host_model (.clk, .dqOut, .dqOe, .sclk, .csN, .dqIn);
  task chk(input string nm, input [7:0] got, input [7:0] exp);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      failCount = failCount + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask
  task modes(input [3:0] e);
    chk("modes", {4'h0, quadMode, dualMode, doubleRate, holdResetEn}, {4'h0, e});
  endtask
  task wr(input [7:0] wd, input integer n, input ddr);
    u_psc_host_model.frame(`PSC_CMD_WRITE, {wd[7:4], `PSC_RSVD_ONES}, n, ddr, rd);
  endtask
  task rdv(input integer n, input ddr);
    u_psc_host_model.frame(`PSC_CMD_READ, 8'h00, n, ddr, rd);
  endtask
  task rescue;
  begin
    @(posedge clk) rescueReq <= 1'b1;
    @(posedge clk) rescueReq <= 1'b0;
    @(posedge clk);
    chk("cfg", cfgValue, 8'hFF);
  end
  endtask
  task tQuad;
  begin
    chk("cfg", cfgValue, 8'hFF);
    modes(4'h1);
    wr(8'h70, 1, 1'b0);
    chk("cfg", cfgValue, 8'h7F);
    modes(4'h9);
    rdv(4, 1'b0);
    chk("rd", rd, 8'h7F);
    rescue;
  end
  endtask
  task tDual;
  begin
    wr(8'hB0, 1, 1'b0);
    modes(4'h5);
    rdv(2, 1'b0);
    chk("rd", rd, 8'hBF);
    wr(8'h30, 2, 1'b0);
    modes(4'h9);
    rescue;
  end
  endtask
  task tRate;
  begin
    wr(8'hD0, 1, 1'b0);
    modes(4'h3);
    rdv(1, 1'b1);
    chk("rd", rd, 8'hDF);
    wr(8'hE0, 1, 1'b1);
    chk("cfg", cfgValue, 8'hEF);
    modes(4'h0);
  end
  endtask
  task tRefuse;
  begin
    u_psc_host_model.frame(8'h5A, 8'h00, 1, 1'b0, rd);
    chk("cfg", cfgValue, 8'hEF);
    @(posedge clk) rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("cfg", cfgValue, 8'hFF);
    modes(4'h1);
  end
  endtask
  task tHold;
  begin
    repeat (3) @(posedge clk);
    u_psc_host_model.holdLow <= 1'b1;
    wr(8'h70, 1, 1'b0);
    u_psc_host_model.holdLow <= 1'b0;
    @(posedge clk);
    chk("cfg", cfgValue, 8'hFF);
    modes(4'h1);
  end
  endtask
  task printVerdict;
  begin
    $display("checked %0d failCount %0d", checked, failCount);
    if (failCount == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    tQuad;
    tDual;
    tRate;
    tRefuse;
    tHold;
    printVerdict;
  end
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      failCount = failCount + 1;
      printVerdict;
    end
  end
endmodule // tb_top
